// file: spcb_ctrl.sv
`timescale 1ns/1ps
`include "spcb_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// Operation
// - mode 01 is default; select pin input
// - mode 1x drives select pin with low bit
// - writing transmit buffer clears empty flag
// - flag sets when byte enters shift register
// - enable bit off stops all transfers
// - mode 00 leaves select pin unconnected
module spcb_ctrl
  import spcb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cfg_wr,
  input wire logic [1:0] select_wiring_mode_field,
  input wire logic port_enable_bit,
  input wire logic master_mode_bit,
  input wire logic tx_wr,
  input wire logic [7:0] tx_wdata,
  output logic tx_buffer_empty_flag,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic busy,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe,
  input wire logic slave_select_pin_in,
  output logic slave_select_pin_out,
  output logic slave_select_pin_oe
);

  ////////////////////////////////////////////////////////////////////////////////
  // configuration

  spcb_mode_t mode_q;
  logic enable_q;
  logic master_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mode_q <= `SPCB_MODE_RESET;
      enable_q <= `SPCB_ENABLE_RESET;
      master_q <= `SPCB_MASTER_RESET;
    end else if (cfg_wr) begin
      mode_q <= select_wiring_mode_field;
      enable_q <= port_enable_bit;
      master_q <= master_mode_bit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin sampling

  logic [3:0] pins_s;
  logic sck_prev_q;

  spcb_sync3 u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pin_in({slave_select_pin_in, miso_in, mosi_in, sck_in}),
    .pin_out(pins_s)
  );

  wire sck_s = pins_s[0];
  wire mosi_s = pins_s[1];
  wire miso_s = pins_s[2];
  wire ss_s = pins_s[3];

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sck_prev_q <= 1'h0;
    end else begin
      sck_prev_q <= sck_s;
    end
  end

  wire sck_rise = sck_s & ~sck_prev_q;
  wire sck_fall = ~sck_s & sck_prev_q;

  ////////////////////////////////////////////////////////////////////////////////
  // mode decode

  wire ss_driven = mode_q[`SPCB_MODE_MASTER_BIT];
  wire three_wire = (mode_q == `SPCB_MODE_3WIRE);
  wire four_wire_in = (mode_q == `SPCB_MODE_4WIRE_SLAVE);
  // in 3-wire mode the select pin is never looked at
  wire slave_sel = enable_q & ~master_q & (three_wire | (four_wire_in & ~ss_s));
  // another master holding select low blocks our start in multi-master wiring
  wire master_free = ~(four_wire_in & ~ss_s);

  ////////////////////////////////////////////////////////////////////////////////
  // transmit buffer

  spcb_state_t st_q;
  logic [7:0] buf_q;
  logic buf_empty_q;

  wire idle = (st_q == SPCB_ST_IDLE);
  wire buf_full = ~buf_empty_q;
  wire start_m = enable_q & master_q & idle & buf_full & master_free;
  wire load_s = enable_q & ~master_q & idle & buf_full;
  wire load = start_m | load_s;
  // a slave clocked with nothing loaded still receives and shifts out zeros
  wire start_s_empty = idle & ~buf_full & slave_sel & sck_rise;
  // a write in the load cycle refills the buffer, so the flag must stay clear
  wire buf_empty_d = tx_wr ? 1'h0 : (load ? 1'h1 : buf_empty_q);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      buf_q <= 8'h00;
      buf_empty_q <= `SPCB_TX_EMPTY_RESET;
    end else begin
      if (tx_wr) begin
        buf_q <= tx_wdata;
      end
      buf_empty_q <= buf_empty_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // shift engine, clock mode 0, msb first

  logic [7:0] tsh_q;
  logic [7:0] rsh_q;
  logic [2:0] cnt_q;
  logic [`SPCB_DIV_W-1:0] div_q;
  logic sck_o_q;
  logic mosi_o_q;
  logic miso_o_q;
  logic [7:0] rx_data_q;
  logic rx_valid_q;

  localparam logic [`SPCB_DIV_W-1:0] HALF_LAST = `SPCB_DIV_W'(`SPCB_SCK_HALF_CYC - 1);
  wire half_done = (div_q == HALF_LAST);
  wire last_bit = (cnt_q == `SPCB_LAST_BIT);
  wire [7:0] rsh_m = {rsh_q[6:0], miso_s};
  wire [7:0] rsh_s = {rsh_q[6:0], mosi_s};

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_q <= SPCB_ST_IDLE;
      tsh_q <= 8'h00;
      rsh_q <= 8'h00;
      cnt_q <= 3'h0;
      div_q <= '0;
      sck_o_q <= 1'h0;
      mosi_o_q <= 1'h0;
      miso_o_q <= 1'h0;
      rx_data_q <= 8'h00;
      rx_valid_q <= 1'h0;
    end else begin
      rx_valid_q <= 1'h0;
      case (st_q)
        SPCB_ST_IDLE: begin
          div_q <= '0;
          cnt_q <= 3'h0;
          sck_o_q <= 1'h0;
          // an unloaded slave answers with zeros
          miso_o_q <= 1'h0;
          if (start_m) begin
            st_q <= SPCB_ST_MSHIFT;
            tsh_q <= buf_q;
            mosi_o_q <= buf_q[7];
          end else if (load_s) begin
            st_q <= SPCB_ST_SSHIFT;
            tsh_q <= buf_q;
            miso_o_q <= buf_q[7];
          end else if (start_s_empty) begin
            st_q <= SPCB_ST_SSHIFT;
            tsh_q <= 8'h00;
            miso_o_q <= 1'h0;
            rsh_q <= rsh_s;
            cnt_q <= 3'h1;
          end
        end
        SPCB_ST_MSHIFT: begin
          if (!enable_q) begin
            st_q <= SPCB_ST_IDLE;
            sck_o_q <= 1'h0;
          end else if (half_done) begin
            div_q <= '0;
            sck_o_q <= ~sck_o_q;
            if (!sck_o_q) begin
              rsh_q <= rsh_m;
            end else if (last_bit) begin
              st_q <= SPCB_ST_IDLE;
              rx_data_q <= rsh_q;
              rx_valid_q <= 1'h1;
            end else begin
              cnt_q <= cnt_q + 3'h1;
              tsh_q <= {tsh_q[6:0], 1'h0};
              mosi_o_q <= tsh_q[6];
            end
          end else begin
            div_q <= div_q + `SPCB_DIV_W'(1);
          end
        end
        SPCB_ST_SSHIFT: begin
          if (!enable_q || master_q) begin
            st_q <= SPCB_ST_IDLE;
          end else if (!slave_sel) begin
            // losing select mid-byte drops the partial byte; an unstarted one waits
            if (cnt_q != 3'h0) begin
              st_q <= SPCB_ST_IDLE;
            end
          end else if (sck_rise) begin
            rsh_q <= rsh_s;
            cnt_q <= cnt_q + 3'h1;
            if (last_bit) begin
              st_q <= SPCB_ST_IDLE;
              rx_data_q <= rsh_s;
              rx_valid_q <= 1'h1;
            end
          end else if (sck_fall && cnt_q != 3'h0) begin
            // the fall closing the previous byte must not shift a fresh load
            tsh_q <= {tsh_q[6:0], 1'h0};
            miso_o_q <= tsh_q[6];
          end
        end
        default: begin
          st_q <= SPCB_ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin drivers, all registered

  logic sck_oe_q;
  logic mosi_oe_q;
  logic miso_oe_q;
  logic ss_o_q;
  logic ss_oe_q;
  logic busy_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sck_oe_q <= 1'h0;
      mosi_oe_q <= 1'h0;
      miso_oe_q <= 1'h0;
      ss_o_q <= 1'h1;
      ss_oe_q <= 1'h0;
      busy_q <= 1'h0;
    end else begin
      sck_oe_q <= enable_q & master_q;
      mosi_oe_q <= enable_q & master_q;
      miso_oe_q <= slave_sel;
      ss_oe_q <= enable_q & ss_driven;
      ss_o_q <= mode_q[`SPCB_MODE_LEVEL_BIT];
      busy_q <= ~idle;
    end
  end

  assign tx_buffer_empty_flag = buf_empty_q;
  assign rx_data = rx_data_q;
  assign rx_valid = rx_valid_q;
  assign busy = busy_q;
  assign sck_out = sck_o_q;
  assign sck_oe = sck_oe_q;
  assign mosi_out = mosi_o_q;
  assign mosi_oe = mosi_oe_q;
  assign miso_out = miso_o_q;
  assign miso_oe = miso_oe_q;
  assign slave_select_pin_out = ss_o_q;
  assign slave_select_pin_oe = ss_oe_q;

endmodule // spcb_ctrl

// file: spcb_defines.svh
`ifndef SPCB_DEFINES_SVH
`define SPCB_DEFINES_SVH

// slave-select wiring mode codes
`define SPCB_MODE_3WIRE 2'h0
`define SPCB_MODE_4WIRE_SLAVE 2'h1
`define SPCB_MODE_RESET 2'h1
`define SPCB_MODE_MASTER_BIT 1
`define SPCB_MODE_LEVEL_BIT 0

// reset values of control and status bits
`define SPCB_ENABLE_RESET 1'h0
`define SPCB_MASTER_RESET 1'h0
`define SPCB_TX_EMPTY_RESET 1'h1

// serial clock timing in master operation
`define SPCB_SYS_CLK_NS 4
`define SPCB_SCK_HALF_NS 64
`define SPCB_DIV_W 8
`define SPCB_SCK_HALF_CYC ((`SPCB_SCK_HALF_NS + `SPCB_SYS_CLK_NS - 1) / `SPCB_SYS_CLK_NS)

// bits per transfer
`define SPCB_LAST_BIT 3'h7

`endif

// file: spcb_pkg.sv
package spcb_pkg;

  typedef enum logic [2:0] {
    SPCB_ST_IDLE = 3'b001,
    SPCB_ST_MSHIFT = 3'b010,
    SPCB_ST_SSHIFT = 3'b100
  } spcb_state_t;

  typedef logic [1:0] spcb_mode_t;

endpackage

// file: spcb_sync3.sv
`timescale 1ns/1ps

// three-stage pin synchroniser; a bit only changes once stages two and three agree
module spcb_sync3 (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [3:0] pin_in,
  output logic [3:0] pin_out
);

  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic [3:0] s3_q;
  logic [3:0] out_q;
  wire [3:0] agree = ~(s2_q ^ s3_q);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s1_q <= 4'h0;
      s2_q <= 4'h0;
      s3_q <= 4'h0;
      out_q <= 4'h0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= (agree & s3_q) | (~agree & out_q);
    end
  end

  assign pin_out = out_q;

endmodule // spcb_sync3

// file: spcb_ctrl_properties.sv
`timescale 1ns/1ps
module spcb_ctrl_properties (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cfg_wr,
  input wire logic [1:0] select_wiring_mode_field,
  input wire logic port_enable_bit,
  input wire logic tx_wr,
  input wire logic tx_buffer_empty_flag,
  input wire logic busy,
  input wire logic sck_oe,
  input wire logic mosi_oe,
  input wire logic miso_oe,
  input wire logic slave_select_pin_out,
  input wire logic slave_select_pin_oe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_cfg(logic [1:0] m);
    cfg_wr && port_enable_bit && select_wiring_mode_field == m;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  AST_RESET_STATE: assert property ($rose(rst_n) |-> tx_buffer_empty_flag && !slave_select_pin_oe)
    else $error("flag or select pin wrong after reset");
  AST_SEL_INPUT: assert property (s_cfg(2'h1) |-> ##2 !slave_select_pin_oe)
    else $error("select pin driven in mode 01");
  AST_SEL_NC: assert property (s_cfg(2'h0) |-> ##2 !slave_select_pin_oe)
    else $error("select pin driven in mode 00");
  AST_SEL_OUT: assert property (cfg_wr && port_enable_bit && select_wiring_mode_field[1] |->
    ##2 slave_select_pin_oe && slave_select_pin_out == $past(select_wiring_mode_field[0], 2))
    else $error("select pin not driven with low mode bit");
  AST_TX_CLEAR: assert property (tx_wr |=> !tx_buffer_empty_flag)
    else $error("empty flag not cleared by write");
  // flag only rises on a load, so the shifter must be running
  AST_TX_SET: assert property ($rose(tx_buffer_empty_flag) |-> ##[0:1] busy)
    else $error("empty flag rose without a load");
  AST_DISABLE: assert property (cfg_wr && !port_enable_bit |->
    ##2 !(sck_oe || mosi_oe || miso_oe || slave_select_pin_oe) ##2 !busy)
    else $error("port active while disabled");
endmodule // spcb_ctrl_properties

// file: spcb_slave_model.sv
`timescale 1ns/1ps
// external slave, clock mode 0, msb first
module spcb_slave_model #(
  parameter logic [7:0] REPLY = 8'h96
) (
  input wire logic sck,
  input wire logic mosi,
  input wire logic ss_n,
  output logic miso,
  output logic [7:0] got
);
  logic [7:0] sh;
  logic [7:0] rsh;
  logic [2:0] n;
  initial begin
    sh = REPLY;
    rsh = 8'h00;
    n = 3'h0;
    miso = 1'b1;
    got = 8'h00;
  end
  always @(negedge ss_n) begin
    sh = REPLY;
    n = 3'h0;
    miso = REPLY[7];
  end
  // released line must not keep its last value
  always @(posedge ss_n) miso = ~miso;
  always @(posedge sck) if (!ss_n) begin
    rsh = {rsh[6:0], mosi};
    if (n == 3'h7) got = rsh;
    n = n + 3'h1;
  end
  always @(negedge sck) if (!ss_n) begin
    sh = (n == 3'h0) ? REPLY : {sh[6:0], 1'b0};
    miso = sh[7];
  end
endmodule // spcb_slave_model

// file: tb.sv
`timescale 1ns/1ps
module tb;
  logic sys_clk = 1'b0, rst_n = 1'b0, cfg_wr = 1'b0, port_enable_bit = 1'b0;
  logic master_mode_bit = 1'b0, tx_wr = 1'b0, model_miso;
  logic [1:0] select_wiring_mode_field = 2'h1;
  logic [7:0] tx_wdata = 8'h00, rx_data, got;
  logic tx_buffer_empty_flag, rx_valid, busy, sck_out, sck_oe, mosi_out, mosi_oe;
  logic miso_out, miso_oe, ss_out, ss_oe;
  logic tb_sck = 1'b0, tb_mosi = 1'b1, tb_ss_n = 1'b1;
  logic [7:0] mi;
  // bench plays master on the link while the port is a slave
  wire sck_w = sck_oe ? sck_out : tb_sck;
  wire mosi_w = mosi_oe ? mosi_out : tb_mosi;
  wire miso_w = miso_oe ? miso_out : model_miso;
  wire ss_w = ss_oe ? ss_out : tb_ss_n;
  int mismatches = 0, comparisons = 0, n, rx_count = 0;
  always @(negedge sys_clk) if (rx_valid === 1'b1) rx_count++;
  always #2 sys_clk = ~sys_clk;
  spcb_ctrl spcb_ctrl_i (.sys_clk, .rst_n, .cfg_wr, .select_wiring_mode_field,
    .port_enable_bit, .master_mode_bit, .tx_wr, .tx_wdata, .tx_buffer_empty_flag, .rx_data,
    .rx_valid, .busy, .sck_in(sck_w), .sck_out, .sck_oe, .mosi_in(mosi_w), .mosi_out, .mosi_oe,
    .miso_in(miso_w), .miso_out, .miso_oe, .slave_select_pin_in(ss_w),
    .slave_select_pin_out(ss_out), .slave_select_pin_oe(ss_oe));
  spcb_slave_model spcb_slave_model_i (.sck(sck_w), .mosi(mosi_w), .ss_n(ss_w),
    .miso(model_miso), .got(got));
  ////////////////////////////////////////////////////////////////////////////////
  task chk1(string what, logic e, logic s);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, e, s);
    end
  endtask
  task chk8(string what, logic [7:0] e, logic [7:0] s);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, e, s);
    end
  endtask
  task cfg(logic [1:0] m, logic en, logic ms = 1'b1);
    @(negedge sys_clk);
    select_wiring_mode_field = m;
    port_enable_bit = en;
    master_mode_bit = ms;
    cfg_wr = 1'b1;
    @(negedge sys_clk);
    cfg_wr = 1'b0;
    repeat (3) @(negedge sys_clk);
  endtask
  // checked one edge late so either clear timing passes
  task wr(logic [7:0] b);
    @(negedge sys_clk);
    tx_wdata = b;
    tx_wr = 1'b1;
    @(negedge sys_clk);
    tx_wr = 1'b0;
    @(negedge sys_clk);
  endtask
  task wait_flag;
    for (n = 0; n < 400 && tx_buffer_empty_flag !== 1'b1; n++) @(negedge sys_clk);
    chk1("flag_wait", 1'b1, tx_buffer_empty_flag);
  endtask
  task wait_rx;
    for (n = 0; n < 600 && rx_valid !== 1'b1; n++) @(negedge sys_clk);
    chk1("rx_wait", 1'b1, rx_valid);
  endtask
  // link clock of 125 ns, standing still between bytes; mode 0, msb first
  task xfer_s(logic [7:0] mo, output logic [7:0] seen);
    @(negedge sys_clk);
    for (int i = 7; i >= 0; i--) begin
      tb_mosi = mo[i];
      #62.5 tb_sck = 1'b1;
      seen[i] = miso_w;
      #62.5 tb_sck = 1'b0;
    end
  endtask
  task close_out;
    $display("counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk) rst_n = 1'b1;
    chk1("empty_flag", 1'b1, tx_buffer_empty_flag);
    chk1("ss_oe", 1'b0, ss_oe);
    $display("test reset done");
    for (int m = 0; m < 4; m++) begin
      cfg(m[1:0], 1'b1);
      chk1("ss_oe", m[1], ss_oe);
      if (m > 1) chk1("ss_out", m[0], ss_out);
    end
    $display("test modes done");
    cfg(2'h3, 1'b0);
    chk1("sck_oe", 1'b0, sck_oe);
    wr(8'ha5);
    chk1("empty_flag", 1'b0, tx_buffer_empty_flag);
    repeat (300) @(negedge sys_clk);
    chk1("busy", 1'b0, busy);
    chk1("empty_flag", 1'b0, tx_buffer_empty_flag);
    $display("test disabled done");
    cfg(2'h2, 1'b1);
    wait_flag;
    chk1("empty_flag", 1'b1, tx_buffer_empty_flag);
    wr(8'h3c);
    chk1("empty_flag", 1'b0, tx_buffer_empty_flag);
    wait_rx;
    chk8("rx_data", 8'h96, rx_data);
    chk8("model_byte", 8'ha5, got);
    wait_flag;
    chk1("empty_flag", 1'b1, tx_buffer_empty_flag);
    wait_rx;
    chk8("model_byte", 8'h3c, got);
    chk8("rx_data", 8'h96, rx_data);
    $display("test transfer done");
    cfg(2'h0, 1'b1, 1'b0);
    chk1("miso_oe", 1'b1, miso_oe);
    chk1("ss_oe", 1'b0, ss_oe);
    wr(8'h5a);
    wr(8'hc3);
    chk1("empty_flag", 1'b0, tx_buffer_empty_flag);
    xfer_s(8'h81, mi);
    chk8("slave_out", 8'h5a, mi);
    chk8("rx_data", 8'h81, rx_data);
    chk1("empty_flag", 1'b1, tx_buffer_empty_flag);
    xfer_s(8'h42, mi);
    chk8("slave_out", 8'hc3, mi);
    chk8("rx_data", 8'h42, rx_data);
    xfer_s(8'h99, mi);
    chk8("slave_out", 8'h00, mi);
    chk8("rx_data", 8'h99, rx_data);
    $display("test three-wire slave done");
    cfg(2'h1, 1'b1, 1'b0);
    chk1("miso_oe", 1'b0, miso_oe);
    wr(8'h6e);
    @(negedge sys_clk) tb_ss_n = 1'b0;
    repeat (6) @(negedge sys_clk);
    chk1("miso_oe", 1'b1, miso_oe);
    xfer_s(8'h17, mi);
    chk8("slave_out", 8'h6e, mi);
    chk8("rx_data", 8'h17, rx_data);
    tb_ss_n = 1'b1;
    chk8("rx_pulses", 8'h06, rx_count[7:0]);
    $display("test four-wire slave done");
    close_out;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    close_out;
  end
endmodule // tb
bind spcb_ctrl spcb_ctrl_properties spcb_ctrl_properties_i (.sys_clk, .rst_n, .cfg_wr,
  .select_wiring_mode_field, .port_enable_bit, .tx_wr, .tx_buffer_empty_flag, .busy, .sck_oe,
  .mosi_oe, .miso_oe, .slave_select_pin_out, .slave_select_pin_oe);
